// file: rtl/vlfr_pkg.sv
// Purpose: Shared constants and types for the output-voltage limit and fault response block.
// Assumes: Command codes arrive already decoded from the management bus.
// Notes: Reset values are plain defaults; nothing here depends on a particular part.
package vlfr_pkg;
    // Command codes of the four held settings and of the clear-faults command.
    localparam logic [7:0] CMD_OV_WARN = 8'h42;
    localparam logic [7:0] CMD_UV_WARN = 8'h43;
    localparam logic [7:0] CMD_UV_FAULT = 8'h44;
    localparam logic [7:0] CMD_UV_RESP = 8'h45;
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    // Values after reset.
    localparam logic [15:0] RST_OV_WARN = 16'hFFFF;
    localparam logic [15:0] RST_UV_WARN = 16'h0000;
    localparam logic [15:0] RST_UV_FAULT = 16'h0000;
    localparam logic [7:0] RST_UV_RESP = 8'h80;
    // Field positions inside the fault reaction byte.
    localparam int RESP_HI = 7;
    localparam int RESP_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int DLY_HI = 2;
    localparam int DLY_LO = 0;
    // Reaction codes and special retry codes.
    localparam logic [1:0] RESP_IGNORE = 2'h0;
    localparam logic [1:0] RESP_DELAY = 2'h1;
    localparam logic [1:0] RESP_DISABLE = 2'h2;
    localparam logic [1:0] RESP_HOLD = 2'h3;
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;
    // Comparator channel indices.
    localparam int CMP_COUNT = 3;
    localparam int CMP_OV_WARN = 0;
    localparam int CMP_UV_WARN = 1;
    localparam int CMP_UV_FAULT = 2;

    typedef enum logic [5:0] {
        ST_RUN = 6'h01,
        ST_DELAY = 6'h02,
        ST_HOLD = 6'h04,
        ST_WAIT = 6'h08,
        ST_TRY = 6'h10,
        ST_LATCHED = 6'h20
    } vlfr_state_e;
endpackage

// file: rtl/vlfr_delay_timer.sv
// Purpose: Counts 2**code delay units, each unit a programmable number of clock cycles.
// Assumes: A start pulse restarts the count even while busy.
// Notes: A unit length of zero is taken as one cycle.
`timescale 1ns/1ps
module vlfr_delay_timer import vlfr_pkg::*; (
    input wire logic sys_clk,
    input wire logic rstnSync,
    input wire logic start,
    input wire logic [2:0] code,
    input wire logic [15:0] unitCycles,
    output logic done
);
    typedef struct packed {
        logic [15:0] tickCnt;
        logic [7:0] unitsLeft;
        logic busy;
        logic done;
    } vlfr_tmr_s;

    vlfr_tmr_s st_r;
    vlfr_tmr_s st_nxt;
    logic [15:0] lastTick;

    assign lastTick = (unitCycles == 16'h0000) ? 16'h0000 : unitCycles - 16'h0001;
    assign done = st_r.done;

    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        if (start) begin
            st_nxt.tickCnt = 16'h0000;
            st_nxt.unitsLeft = 8'(8'h01 << code) - 8'h01;
            st_nxt.busy = 1'b1;
        end else if (st_r.busy) begin
            if (st_r.tickCnt >= lastTick) begin
                st_nxt.tickCnt = 16'h0000;
                if (st_r.unitsLeft == 8'h00) begin
                    st_nxt.busy = 1'b0;
                    st_nxt.done = 1'b1;
                end else begin
                    st_nxt.unitsLeft = st_r.unitsLeft - 8'h01;
                end
            end else begin
                st_nxt.tickCnt = st_r.tickCnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Helper for the length check only.
    logic [23:0] elapsed;
    logic [23:0] expected;
    always_ff @(posedge sys_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            elapsed <= 24'h00_0000;
            expected <= 24'h00_0000;
        end else if (start) begin
            elapsed <= 24'h00_0000;
            expected <= 24'({8'h00, lastTick + 16'h0001} * (24'h00_0001 << code));
        end else if (st_r.busy) begin
            elapsed <= elapsed + 24'h00_0001;
        end
    end

    chk_delay_length: assert property (@(posedge sys_clk) disable iff (!rstnSync)
        st_r.done |-> elapsed == expected) else $error("Delay length differs from units times unit size.");
endmodule // vlfr_delay_timer

// file: rtl/vlfr_limit_compare.sv
// Purpose: Compares each output-voltage sample with the two warning and the fault thresholds.
// Assumes: Samples and thresholds share the same unsigned output-voltage coding.
// Notes: Flags hold their last value between samples.
`timescale 1ns/1ps
module vlfr_limit_compare import vlfr_pkg::*; (
    input wire logic sys_clk,
    input wire logic rstnSync,
    input wire logic [15:0] voutSample,
    input wire logic voutValid,
    input wire logic [15:0] ovWarnThr,
    input wire logic [15:0] uvWarnThr,
    input wire logic [15:0] uvFaultThr,
    output logic overWarn,
    output logic underWarn,
    output logic underFault
);
    typedef struct packed {
        logic [CMP_COUNT-1:0] hit;
    } vlfr_cmp_s;

    vlfr_cmp_s st_r;
    vlfr_cmp_s st_nxt;
    logic [CMP_COUNT-1:0] hitNow;
    logic [15:0] thr [CMP_COUNT];

    assign thr[CMP_OV_WARN] = ovWarnThr;
    assign thr[CMP_UV_WARN] = uvWarnThr;
    assign thr[CMP_UV_FAULT] = uvFaultThr;

    for (genvar i = 0; i < CMP_COUNT; i++) begin : gCmp
        if (i == CMP_OV_WARN) begin : gAbove
            assign hitNow[i] = voutSample > thr[i];
        end else begin : gBelow
            assign hitNow[i] = voutSample < thr[i];
        end
    end

    always_comb begin
        st_nxt = st_r;
        if (voutValid) begin
            st_nxt.hit = hitNow;
        end
    end

    always_ff @(posedge sys_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign overWarn = st_r.hit[CMP_OV_WARN];
    assign underWarn = st_r.hit[CMP_UV_WARN];
    assign underFault = st_r.hit[CMP_UV_FAULT];

    chk_fault_below: assert property (@(posedge sys_clk) disable iff (!rstnSync)
        voutValid && voutSample < uvFaultThr |=> underFault) else $error("Under-voltage fault not declared.");
    chk_warn_above: assert property (@(posedge sys_clk) disable iff (!rstnSync)
        voutValid && voutSample <= ovWarnThr |=> !overWarn) else $error("Over-voltage warning raised wrongly.");
endmodule // vlfr_limit_compare

// file: rtl/vlfr_top.sv
// Purpose: Output-voltage limits, warning flags and under-voltage fault reaction with retries.
// Assumes: Commands arrive decoded; outputOnReq already combines control pin and operation command.
// Notes: The delay unit size comes from outside as a count of clock cycles.
// Contract
// - Hold sixteen-bit over-voltage warning threshold, read/write.
// - Hold sixteen-bit under-voltage warning threshold.
// - Hold sixteen-bit under-voltage fault threshold.
// - Reaction 00: keep running through the fault.
// - Reaction 01: run for delay, then retry.
// - Reaction 10: disable at once, then retry.
// - Reaction 11: off while fault, resume after.
// - Clear latch by bit, command or reset.
// - Clear latch by off-then-on output command.
// - Retry code 000: no restart, stay off.
// - Retry code 001: one restart, then off.
// - Retry code 010: two restarts, then off.
// - Retry code 111: restart without limit.
// - Attempt spacing equals delay count times unit.
// - Delay code n means 2**n units.
// - Unit size comes from a separate setting.
// - Retry codes 011-110: three to six restarts.
// - Endless retries stop on off, bias loss, other fault.
`timescale 1ns/1ps
module vlfr_top import vlfr_pkg::*; (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic cmdWrite,
    input wire logic cmdRead,
    input wire logic [7:0] cmdCode,
    input wire logic [15:0] cmdWrData,
    output logic [15:0] rdData,
    output logic rdValid,
    input wire logic clearUvStatus,
    input wire logic faultResetIn,
    input wire logic outputOnReq,
    input wire logic otherShutdown,
    input wire logic [15:0] delayUnitCycles,
    input wire logic [15:0] voutSample,
    input wire logic voutValid,
    output logic outputEnable,
    output logic faultLatched,
    output logic uvFaultFlag,
    output logic ovWarnFlag,
    output logic uvWarnFlag
);
    typedef struct packed {
        logic [15:0] ovWarnThr;
        logic [15:0] uvWarnThr;
        logic [15:0] uvFaultThr;
        logic [7:0] uvResp;
        logic [15:0] rdData;
        logic rdValid;
        logic ovWarnFlag;
        logic uvWarnFlag;
        logic uvFaultFlag;
        logic outEn;
        logic latched;
        logic onPrev;
        logic [2:0] retriesLeft;
        vlfr_state_e fsm;
    } vlfr_top_s;

    vlfr_top_s st_r;
    vlfr_top_s st_nxt;
    logic [1:0] rstSync_r;
    logic rstnSync;
    logic overWarn;
    logic underWarn;
    logic uvFault;
    logic tDone;
    logic timerStart;
    logic goRetry;
    logic clrEvt;
    logic onOk;
    logic [1:0] respCode;
    logic [2:0] retryCode;

    // Reset enters asynchronously and leaves synchronously only after two clean edges.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rstSync_r <= 2'h0;
        end else begin
            rstSync_r <= {rstSync_r[0], 1'b1};
        end
    end
    assign rstnSync = rstSync_r[1];

    vlfr_limit_compare uCmp (
        .sys_clk(sys_clk),
        .rstnSync(rstnSync),
        .voutSample(voutSample),
        .voutValid(voutValid),
        .ovWarnThr(st_r.ovWarnThr),
        .uvWarnThr(st_r.uvWarnThr),
        .uvFaultThr(st_r.uvFaultThr),
        .overWarn(overWarn),
        .underWarn(underWarn),
        .underFault(uvFault)
    );

    vlfr_delay_timer uTmr (
        .sys_clk(sys_clk),
        .rstnSync(rstnSync),
        .start(timerStart),
        .code(st_r.uvResp[DLY_HI:DLY_LO]),
        .unitCycles(delayUnitCycles),
        .done(tDone)
    );

    assign respCode = st_r.uvResp[RESP_HI:RESP_LO];
    assign retryCode = st_r.uvResp[RETRY_HI:RETRY_LO];
    assign onOk = outputOnReq && !otherShutdown;
    assign clrEvt = clearUvStatus || faultResetIn || (cmdWrite && cmdCode == CMD_CLEAR_FAULTS)
        || (outputOnReq && !st_r.onPrev);

    always_comb begin
        st_nxt = st_r;
        timerStart = 1'b0;
        goRetry = 1'b0;
        st_nxt.onPrev = outputOnReq;
        st_nxt.rdValid = cmdRead;
        if (cmdWrite) begin
            case (cmdCode)
                CMD_OV_WARN: st_nxt.ovWarnThr = cmdWrData;
                CMD_UV_WARN: st_nxt.uvWarnThr = cmdWrData;
                CMD_UV_FAULT: st_nxt.uvFaultThr = cmdWrData;
                CMD_UV_RESP: st_nxt.uvResp = cmdWrData[7:0];
                default: st_nxt.uvResp = st_r.uvResp;
            endcase
        end
        if (cmdRead) begin
            case (cmdCode)
                CMD_OV_WARN: st_nxt.rdData = st_r.ovWarnThr;
                CMD_UV_WARN: st_nxt.rdData = st_r.uvWarnThr;
                CMD_UV_FAULT: st_nxt.rdData = st_r.uvFaultThr;
                CMD_UV_RESP: st_nxt.rdData = {8'h00, st_r.uvResp};
                default: st_nxt.rdData = 16'h0000;
            endcase
        end
        // A new event wins over a clear arriving in the same cycle.
        st_nxt.ovWarnFlag = (st_r.ovWarnFlag && !clrEvt) || overWarn;
        st_nxt.uvWarnFlag = (st_r.uvWarnFlag && !clrEvt) || underWarn;
        st_nxt.uvFaultFlag = (st_r.uvFaultFlag && !clrEvt) || (uvFault && outputOnReq);
        case (st_r.fsm)
            ST_RUN: begin
                if (uvFault && onOk) begin
                    case (respCode)
                        RESP_IGNORE: st_nxt.fsm = ST_RUN;
                        RESP_DELAY: begin
                            timerStart = 1'b1;
                            st_nxt.fsm = ST_DELAY;
                        end
                        RESP_DISABLE: goRetry = 1'b1;
                        default: st_nxt.fsm = ST_HOLD;
                    endcase
                end
            end
            ST_DELAY: begin
                if (tDone) begin
                    if (uvFault) begin
                        goRetry = 1'b1;
                    end else begin
                        st_nxt.fsm = ST_RUN;
                    end
                end
            end
            ST_HOLD: begin
                if (!uvFault) begin
                    st_nxt.fsm = ST_RUN;
                end
            end
            ST_WAIT: begin
                if (tDone) begin
                    timerStart = 1'b1;
                    st_nxt.fsm = ST_TRY;
                    if (st_r.retriesLeft != RETRY_FOREVER) begin
                        st_nxt.retriesLeft = st_r.retriesLeft - 3'h1;
                    end
                end
            end
            ST_TRY: begin
                if (tDone) begin
                    if (!uvFault) begin
                        st_nxt.fsm = ST_RUN;
                    end else if (st_r.retriesLeft == 3'h0) begin
                        st_nxt.fsm = ST_LATCHED;
                    end else begin
                        // Next attempt starts as the last one is judged, so spacing stays one delay.
                        timerStart = 1'b1;
                        if (st_r.retriesLeft != RETRY_FOREVER) begin
                            st_nxt.retriesLeft = st_r.retriesLeft - 3'h1;
                        end
                    end
                end
            end
            ST_LATCHED: begin
                if (clrEvt) begin
                    st_nxt.fsm = ST_RUN;
                end
            end
            default: st_nxt.fsm = ST_RUN;
        endcase
        if (goRetry) begin
            if (retryCode == RETRY_NONE) begin
                st_nxt.fsm = ST_LATCHED;
            end else begin
                st_nxt.retriesLeft = retryCode;
                timerStart = 1'b1;
                st_nxt.fsm = ST_WAIT;
            end
        end
        // Commanding off or another shutdown ends any reaction, endless retries included.
        if (!onOk) begin
            st_nxt.fsm = ST_RUN;
            timerStart = 1'b0;
        end
        st_nxt.outEn = onOk && (st_nxt.fsm == ST_RUN || st_nxt.fsm == ST_DELAY || st_nxt.fsm == ST_TRY);
        st_nxt.latched = st_nxt.fsm == ST_LATCHED;
    end

    always_ff @(posedge sys_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            st_r <= '{ovWarnThr: RST_OV_WARN, uvWarnThr: RST_UV_WARN, uvFaultThr: RST_UV_FAULT,
                uvResp: RST_UV_RESP, onPrev: 1'b1, fsm: ST_RUN, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdData = st_r.rdData;
    assign rdValid = st_r.rdValid;
    assign outputEnable = st_r.outEn;
    assign faultLatched = st_r.latched;
    assign uvFaultFlag = st_r.uvFaultFlag;
    assign ovWarnFlag = st_r.ovWarnFlag;
    assign uvWarnFlag = st_r.uvWarnFlag;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstnSync);

    // Named steps of the reaction that the checks below are built from.
    sequence seqFaultInRun;
        st_r.fsm == ST_RUN && uvFault && onOk;
    endsequence
    sequence seqAttemptFails;
        st_r.fsm == ST_TRY && tDone && uvFault && onOk;
    endsequence
    sequence seqAttemptStarts;
        st_r.fsm == ST_WAIT && tDone && onOk;
    endsequence

    chk_reg_write: assert property (cmdWrite && cmdCode == CMD_OV_WARN |=> st_r.ovWarnThr == $past(cmdWrData))
        else $error("Threshold write not stored.");

    chk_uvwarn_write: assert property (cmdWrite && cmdCode == CMD_UV_WARN
        |=> st_r.uvWarnThr == $past(cmdWrData)) else $error("Warning threshold write not stored.");

    chk_reg_readback: assert property (cmdRead && !cmdWrite && cmdCode == CMD_UV_FAULT
        |=> rdValid && rdData == st_r.uvFaultThr) else $error("Fault threshold read back wrong.");

    chk_ignore_runs: assert property (seqFaultInRun ##0 respCode == RESP_IGNORE
        |=> outputEnable && st_r.fsm == ST_RUN) else $error("Ignored fault disturbed output.");

    chk_delay_runs: assert property (st_r.fsm == ST_DELAY && !tDone && onOk |=> outputEnable)
        else $error("Output dropped during delayed reaction.");

    chk_disable_now: assert property (seqFaultInRun ##0 respCode == RESP_DISABLE
        |=> !outputEnable) else $error("Output not disabled at once.");

    chk_hold_off: assert property (st_r.fsm == ST_HOLD && uvFault |=> !outputEnable ##1 1'b1)
        else $error("Output on while fault present.");

    chk_hold_resume: assert property (st_r.fsm == ST_HOLD && !uvFault && onOk |=> outputEnable)
        else $error("Output did not resume after fault left.");

    chk_latch_clear: assert property (st_r.fsm == ST_LATCHED && clearUvStatus && onOk
        |=> st_r.fsm == ST_RUN && outputEnable) else $error("Latched fault not cleared.");

    chk_on_clear: assert property (uvFaultFlag && outputOnReq && !st_r.onPrev && !uvFault
        |=> !uvFaultFlag) else $error("Flag not cleared by off-then-on command.");

    chk_no_retry: assert property (goRetry && retryCode == RETRY_NONE && onOk |=> faultLatched && !outputEnable)
        else $error("Restart attempted with zero retries.");

    chk_last_retry: assert property (seqAttemptFails ##0 st_r.retriesLeft == 3'h0
        |=> faultLatched && !outputEnable) else $error("Output not latched off after last attempt.");

    chk_retry_count: assert property (seqAttemptStarts ##0 st_r.retriesLeft != RETRY_FOREVER
        |=> st_r.retriesLeft == $past(st_r.retriesLeft) - 3'h1) else $error("Restart attempt not counted.");

    chk_endless_retry: assert property (seqAttemptFails ##0 st_r.retriesLeft == RETRY_FOREVER
        |=> st_r.fsm == ST_TRY && st_r.retriesLeft == RETRY_FOREVER) else $error("Endless retry stopped.");

    chk_attempt_on: assert property (seqAttemptStarts |=> outputEnable && st_r.fsm == ST_TRY)
        else $error("Restart attempt did not enable output.");

    chk_retry_stop: assert property (st_r.fsm != ST_RUN && !outputOnReq |=> st_r.fsm == ST_RUN && !outputEnable)
        else $error("Reaction continued after output commanded off.");

    // The sticky flags must follow their events even while the output is held off.
    chk_warn_flag: assert property (overWarn |=> ovWarnFlag)
        else $error("Over-voltage warning flag not set.");

    chk_fault_flag: assert property (uvFault && outputOnReq |=> uvFaultFlag)
        else $error("Under-voltage fault flag not set.");
endmodule // vlfr_top

// file: verification/vlfr_host_model.sv
// Purpose: Management-bus host that writes and reads the limit and reaction settings.
// Assumes: Commands arrive decoded; strobes are single-cycle pulses launched at the falling edge.
// Notes: Data is inverted after each write so a stale bus value can never pass as a good one.
`timescale 1ns/1ps
module vlfr_host_model (
    input wire logic sys_clk,
    output logic cmdWrite,
    output logic cmdRead,
    output logic [7:0] cmdCode,
    output logic [15:0] cmdWrData,
    input wire logic [15:0] rdData,
    input wire logic rdValid
);
    initial begin
        cmdWrite = 1'b0;
        cmdRead = 1'b0;
        cmdCode = 8'h00;
        cmdWrData = 16'h0000;
    end

    task automatic wr(input logic [7:0] code, input logic [15:0] data);
        @(negedge sys_clk);
        cmdCode <= code;
        cmdWrData <= data;
        cmdWrite <= 1'b1;
        @(negedge sys_clk);
        cmdWrite <= 1'b0;
        cmdWrData <= ~data;
    endtask

    // A missing answer leaves the result unknown, so the caller's compare fails.
    task automatic rd(input logic [7:0] code, output logic [15:0] data);
        data = 16'hxxxx;
        @(negedge sys_clk);
        cmdCode <= code;
        cmdRead <= 1'b1;
        @(negedge sys_clk);
        cmdRead <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (rdValid === 1'b1) begin
                data = rdData;
                break;
            end
            @(negedge sys_clk);
        end
    endtask
endmodule // vlfr_host_model

// file: verification/vout_limit_fault_response_tb.sv
// Purpose: Self-checking bench for the output-voltage limits and under-voltage fault reaction.
// Assumes: Inputs change at the falling edge; one delay unit is a small random number of cycles.
// Notes: Retry timing is checked within a window of a few cycles of registering latency.
`timescale 1ns/1ps
module vout_limit_fault_response_tb import vlfr_pkg::*;;
    localparam logic [15:0] GOOD = 16'h4000;
    localparam logic [15:0] BAD = 16'h0800;
    logic sysClk, rstn, cmdWrite, cmdRead, rdValid, clearUvStatus, faultResetIn, outputOnReq, otherShutdown;
    logic voutValid, outputEnable, faultLatched, uvFaultFlag, ovWarnFlag, uvWarnFlag;
    logic [7:0] cmdCode;
    logic [15:0] cmdWrData, rdData, delayUnitCycles, voutSample, rdv, v;
    int regModel[int];
    int errTotal, checksDone, hi, tLow, tRise, unit, dl, k;
    int retryList[4] = '{0, 2, 3, 6};

    vlfr_top u_vlfr_top (.sys_clk(sysClk), .rstn(rstn), .cmdWrite(cmdWrite), .cmdRead(cmdRead),
        .cmdCode(cmdCode), .cmdWrData(cmdWrData), .rdData(rdData), .rdValid(rdValid),
        .clearUvStatus(clearUvStatus), .faultResetIn(faultResetIn), .outputOnReq(outputOnReq),
        .otherShutdown(otherShutdown), .delayUnitCycles(delayUnitCycles), .voutSample(voutSample),
        .voutValid(voutValid), .outputEnable(outputEnable), .faultLatched(faultLatched),
        .uvFaultFlag(uvFaultFlag), .ovWarnFlag(ovWarnFlag), .uvWarnFlag(uvWarnFlag));
    vlfr_host_model u_vlfr_host_model (.sys_clk(sysClk), .cmdWrite(cmdWrite), .cmdRead(cmdRead),
        .cmdCode(cmdCode), .cmdWrData(cmdWrData), .rdData(rdData), .rdValid(rdValid));

    initial begin
        sysClk = 1'b0;
        forever #4 sysClk = ~sysClk;
    end

    task automatic end_of_test;
        if (errTotal == 0 && checksDone > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chkVal(input logic [15:0] got, input logic [15:0] exp);
        checksDone++;
        if (got !== exp) begin
            errTotal++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkRange(input int got, input int lo, input int hiLim);
        checksDone++;
        if (got < lo || got > hiLim) begin
            errTotal++;
            $display("FAIL t=%0t got=%h exp=%h..%h", $time, got, lo, hiLim);
        end
    endtask

    task automatic wrReg(input logic [7:0] code, input logic [15:0] data);
        u_vlfr_host_model.wr(code, data);
        regModel[code] = data;
    endtask

    task automatic samp(input logic [15:0] s);
        @(negedge sysClk);
        voutSample <= s;
        voutValid <= 1'b1;
        @(negedge sysClk);
        voutValid <= 1'b0;
    endtask

    task automatic clearBy(input int how);
        case (how)
            0: begin
                @(negedge sysClk);
                clearUvStatus <= 1'b1;
                @(negedge sysClk);
                clearUvStatus <= 1'b0;
            end
            1: begin
                @(negedge sysClk);
                faultResetIn <= 1'b1;
                @(negedge sysClk);
                faultResetIn <= 1'b0;
            end
            2: u_vlfr_host_model.wr(CMD_CLEAR_FAULTS, 16'h0000);
            default: begin
                @(negedge sysClk);
                outputOnReq <= 1'b0;
                repeat (3) @(negedge sysClk);
                outputOnReq <= 1'b1;
            end
        endcase
        repeat (4) @(negedge sysClk);
    endtask

    // Starts from a cleared, running state so each reaction is seen from its first cycle.
    task automatic arm(input logic [1:0] resp, input logic [2:0] retry, input logic [2:0] dly);
        samp(GOOD);
        clearBy(1);
        wrReg(CMD_UV_RESP, {8'h00, resp, retry, dly});
        samp(BAD);
    endtask

    task automatic watch(input int n);
        hi = 0;
        tLow = n;
        tRise = n;
        for (int i = 0; i < n; i++) begin
            @(negedge sysClk);
            if (outputEnable === 1'b1) begin
                hi++;
                if (tLow < n && tRise == n) tRise = i;
            end else if (tLow == n) begin
                tLow = i;
            end
        end
    endtask

    initial begin
        #320000;
        errTotal++;
        end_of_test();
    end

    initial begin
        void'($urandom(32'h48e8_f228));
        {rstn, clearUvStatus, faultResetIn, otherShutdown, voutValid} = 5'h00;
        outputOnReq = 1'b1;
        voutSample = GOOD;
        delayUnitCycles = 16'h0001;
        errTotal = 0;
        checksDone = 0;
        repeat (10) @(negedge sysClk);
        rstn <= 1'b1;
        repeat (4) @(negedge sysClk);
        regModel[CMD_OV_WARN] = RST_OV_WARN;
        regModel[CMD_UV_WARN] = RST_UV_WARN;
        regModel[CMD_UV_FAULT] = RST_UV_FAULT;
        regModel[CMD_UV_RESP] = {8'h00, RST_UV_RESP};
        foreach (regModel[a]) begin
            u_vlfr_host_model.rd(a[7:0], rdv);
            chkVal(rdv, regModel[a][15:0]);
        end
        u_vlfr_host_model.rd(8'h46, rdv);
        chkVal(rdv, 16'h0000);
        for (int i = 0; i < 12; i++) begin
            k = 'h42 + $urandom_range(3);
            v = 16'($urandom);
            if (k == 'h45) v[15:8] = 8'h00;
            wrReg(k[7:0], v);
            u_vlfr_host_model.rd(k[7:0], rdv);
            chkVal(rdv, regModel[k][15:0]);
        end
        wrReg(CMD_OV_WARN, 16'h8000);
        wrReg(CMD_UV_WARN, 16'h2000);
        wrReg(CMD_UV_FAULT, 16'h1000);
        unit = $urandom_range(4, 1);
        delayUnitCycles <= 16'(unit);
        arm(2'h0, 3'h0, 3'h0);
        repeat (20) @(negedge sysClk);
        chkVal(16'({uvFaultFlag, outputEnable, faultLatched}), 16'h0006);
        samp(GOOD);
        clearBy(0);
        samp(16'h9000);
        repeat (3) @(negedge sysClk);
        chkVal(16'({ovWarnFlag, uvWarnFlag, uvFaultFlag, outputEnable}), 16'h0009);
        samp(16'h1800);
        repeat (3) @(negedge sysClk);
        chkVal(16'({uvWarnFlag, uvFaultFlag, outputEnable}), 16'h0005);
        arm(2'h3, 3'h0, 3'h0);
        repeat (4) @(negedge sysClk);
        chkVal(16'(outputEnable), 16'h0000);
        samp(GOOD);
        repeat (4) @(negedge sysClk);
        chkVal(16'(outputEnable), 16'h0001);
        arm(2'h1, 3'h0, 3'h2);
        watch(4 * unit + 20);
        chkRange(tLow, 4 * unit, 4 * unit + 4);
        chkVal(16'(faultLatched), 16'h0001);
        for (int d = 0; d < 8; d++) begin
            dl = (1 << d) * unit;
            arm(2'h2, 3'h1, d[2:0]);
            watch(3 * dl + 20);
            chkRange(tRise - tLow, dl, dl + 2);
            chkRange(hi, dl, dl + 2);
            chkVal(16'(faultLatched), 16'h0001);
        end
        foreach (retryList[j]) begin
            arm(2'h2, retryList[j][2:0], 3'h0);
            watch(retryList[j] * (unit + 3) + 3 * unit + 20);
            chkRange(hi, retryList[j] * unit, retryList[j] * (unit + 1) + 2);
            chkVal(16'({faultLatched, outputEnable}), 16'h0002);
        end
        arm(2'h2, 3'h7, 3'h0);
        watch(200);
        chkRange(hi, 20, 200);
        chkVal(16'(faultLatched), 16'h0000);
        // A stopped retry loop restarts from the off phase, so the output stays low one cycle after release.
        for (int s = 0; s < 2; s++) begin
            {outputOnReq, otherShutdown} <= (s == 0) ? 2'b00 : 2'b11;
            repeat (5) @(negedge sysClk);
            chkVal(16'({faultLatched, outputEnable}), 16'h0000);
            {outputOnReq, otherShutdown} <= 2'b10;
            @(negedge sysClk);
            chkVal(16'(outputEnable), 16'h0000);
            repeat (3 * unit + 4) @(negedge sysClk);
        end
        for (int h = 0; h < 4; h++) begin
            arm(2'h2, 3'h0, 3'h0);
            repeat (10) @(negedge sysClk);
            chkVal(16'(faultLatched), 16'h0001);
            samp(GOOD);
            clearBy(h);
            chkVal(16'({faultLatched, outputEnable}), 16'h0001);
        end
        end_of_test();
    end
endmodule // vout_limit_fault_response_tb
